/* design/acc_conv_ctrl.sv */
// control logic around a 12-bit successive-approximation converter
// assumes an 8-bit register port with one-cycle read/write strobes,
// and an analog core that samples on sampleHold and reports the code
// in analogCode at the end of the sixteenth converter clock
//
// Function
// R1: enable bit powers converter; when clear no conversions happen.
// R2: track mode 0 tracks continuously except during conversion.
// R3: done flag sets on busy falling edge, held until software clears.
// R4: source 00: writing 1 to busy starts conversion; 0 ignored.
// R5: delayed mode with software start tracks 3 converter clocks first.
// R6: source 01: timer B overflow starts; delayed mode tracks 3 clocks.
// R7: source 10: strobe rising edge starts; tracks while strobe low.
// R8: source 11: timer A overflow starts; delayed mode tracks 3 clocks.
// R9: alignment bit selects right (0) or left (1) justification.
// R10: result is 12 bits across high and low result registers.
// R11: conversion lasts 16 converter clocks after tracking ends.
// R12: window compare runs automatically after each conversion.
// R13: each 16-bit limit has separately writable high and low bytes.
// R14: window hit flag readable and drives an interrupt request.
// R15: hit means inside or outside window depending on limit order.
// R16: upper limit low byte resets to all ones.
// R17: lower above upper: hit only strictly between the limits.
// R18: busy bit reads 1 throughout conversion, else 0; code also reads 1 during delayed-mode tracking.
// R19: software clears hit flag by writing 0; hardware never clears.
`include "acc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module acc_conv_ctrl
    import acc_pkg::*;
#(
    parameter int RES_W = 12
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [7:0]       regAddr,
    input  wire logic [7:0]       regWdata,
    input  wire logic             regWrite,
    input  wire logic             regRead,
    output logic      [7:0]       regRdata,
    input  wire logic             timerAOvf,
    input  wire logic             timerBOvf,
    input  wire logic             extConvertStrobe,
    input  wire logic [RES_W-1:0] analogCode,
    output logic                  converterPowered,
    output logic                  sampleHold,
    output logic                  convDoneIrq,
    output logic                  windowHitIrq
);

    // registers
    logic             converterOn_reg;
    logic             trackSelect_reg;
    logic             convDoneFlag_reg;
    logic [1:0]       startSourceSel_reg;
    logic             windowHitFlag_reg;
    logic             leftAlignSel_reg;
    logic [7:0]       upperLow_reg;
    logic [7:0]       upperHigh_reg;
    logic [7:0]       lowerLow_reg;
    logic [7:0]       lowerHigh_reg;
    logic [7:0]       clkDiv_reg;
    logic [RES_W-1:0] result_reg;
    logic [7:0]       divCnt_reg;
    logic [4:0]       phaseCnt_reg;
    logic             strobePrev_reg;
    acc_state_t       state_reg;

    logic             sarTick;
    logic             ctrlWrite;
    logic             softStart;
    logic             startReq;
    logic             convEnd;
    logic             hitNow;
    logic [15:0]      resAligned;
    logic [15:0]      upperWord;
    logic [15:0]      lowerWord;
    acc_src_t         src;

    // window test: limit order picks inside or outside sense
    function automatic logic win_hit(input logic [15:0] v,
                                     input logic [15:0] gt,
                                     input logic [15:0] lt);
        if (lt > gt) begin
            win_hit = (v > gt) && (v < lt); // R17
        end else begin
            win_hit = (v > gt) || (v < lt); // R15
        end
    endfunction : win_hit

    assign src       = acc_src_t'(startSourceSel_reg);
    assign ctrlWrite = regWrite && (regAddr == `ACC_OFF_CONTROL);
    assign upperWord = {upperHigh_reg, upperLow_reg};
    assign lowerWord = {lowerHigh_reg, lowerLow_reg};

    // software start only on a 1 written to the busy bit
    assign softStart = ctrlWrite && regWdata[`ACC_BIT_ACTIVE]; // R4

    // start source mux; starts are ignored while a conversion runs
    always_comb begin
        unique case (src)
            ACC_SRC_SOFT:   startReq = softStart; // R4
            ACC_SRC_TIMERB: startReq = timerBOvf; // R6
            ACC_SRC_STROBE: startReq = extConvertStrobe &&
                                       !strobePrev_reg; // R7
            ACC_SRC_TIMERA: startReq = timerAOvf; // R8
        endcase
    end

    // converter clock enable; divider held while converter is off
    assign sarTick = converterOn_reg && (divCnt_reg == 8'h00);

    always_ff @(posedge mclk) begin
        if (rst || !converterOn_reg || divCnt_reg == 8'h00) begin
            divCnt_reg <= clkDiv_reg;
        end else begin
            divCnt_reg <= divCnt_reg - 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            strobePrev_reg <= 1'b0;
        end else begin
            strobePrev_reg <= extConvertStrobe;
        end
    end

    assign convEnd = (state_reg == ACC_CONV) && sarTick &&
                     (phaseCnt_reg == 5'(`ACC_CONV_CLKS - 1)); // R11

    // conversion sequencer
    always_ff @(posedge mclk) begin
        if (rst || !converterOn_reg) begin
            state_reg    <= ACC_IDLE; // R1
            phaseCnt_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                ACC_IDLE: begin
                    phaseCnt_reg <= 5'h00;
                    if (startReq) begin
                        // strobe mode tracked while low already
                        if (trackSelect_reg && src != ACC_SRC_STROBE) begin
                            state_reg <= ACC_TRACK; // R5
                        end else begin
                            state_reg <= ACC_CONV;
                        end
                    end
                end
                ACC_TRACK: begin
                    if (sarTick) begin
                        if (phaseCnt_reg == 5'(`ACC_TRACK_CLKS - 1)) begin
                            state_reg    <= ACC_CONV; // R6
                            phaseCnt_reg <= 5'h00;
                        end else begin
                            phaseCnt_reg <= phaseCnt_reg + 5'h01; // R8
                        end
                    end
                end
                ACC_CONV: begin
                    if (convEnd) begin
                        state_reg    <= ACC_IDLE;
                        phaseCnt_reg <= 5'h00;
                    end else if (sarTick) begin
                        phaseCnt_reg <= phaseCnt_reg + 5'h01; // R11
                    end
                end
                default: begin
                    state_reg    <= ACC_IDLE;
                    phaseCnt_reg <= 5'h00;
                end
            endcase
        end
    end

    // track/hold control to the analog core
    always_comb begin
        if (!converterOn_reg || state_reg == ACC_CONV) begin
            sampleHold = 1'b0;
        end else if (!trackSelect_reg) begin
            sampleHold = 1'b1; // R2
        end else if (src == ACC_SRC_STROBE) begin
            sampleHold = !extConvertStrobe; // R7
        end else begin
            sampleHold = (state_reg == ACC_TRACK);
        end
    end

    // result capture at the end of the conversion
    always_ff @(posedge mclk) begin
        if (rst) begin
            result_reg <= '0;
        end else if (convEnd) begin
            result_reg <= analogCode; // R10
        end
    end

    // alignment of the 12-bit code into the 16-bit register pair
    assign resAligned = leftAlignSel_reg ?
                        {result_reg, {(16 - RES_W){1'b0}}} :
                        {{(16 - RES_W){1'b0}}, result_reg}; // R9

    // compare the fresh code, aligned as the limits are
    assign hitNow = win_hit(leftAlignSel_reg ?
                            {analogCode, {(16 - RES_W){1'b0}}} :
                            {{(16 - RES_W){1'b0}}, analogCode},
                            upperWord, lowerWord); // R12

    // control register; hardware sets win over software clears
    always_ff @(posedge mclk) begin
        if (rst) begin
            converterOn_reg    <= 1'(`ACC_RST_CONTROL >> `ACC_BIT_ON);
            trackSelect_reg    <= 1'b0;
            convDoneFlag_reg   <= 1'b0;
            startSourceSel_reg <= 2'b00;
            windowHitFlag_reg  <= 1'b0;
            leftAlignSel_reg   <= 1'b0;
        end else begin
            if (ctrlWrite) begin
                converterOn_reg    <= regWdata[`ACC_BIT_ON]; // R1
                trackSelect_reg    <= regWdata[`ACC_BIT_TRACK];
                startSourceSel_reg <= regWdata[`ACC_BIT_SRC_HI:
                                               `ACC_BIT_SRC_LO];
                leftAlignSel_reg   <= regWdata[`ACC_BIT_LEFT];
            end
            if (convEnd) begin
                convDoneFlag_reg <= 1'b1; // R3
            end else if (ctrlWrite) begin
                convDoneFlag_reg <= regWdata[`ACC_BIT_DONE];
            end
            if (convEnd && hitNow) begin
                windowHitFlag_reg <= 1'b1; // R14
            end else if (ctrlWrite) begin
                windowHitFlag_reg <= regWdata[`ACC_BIT_HIT]; // R19
            end
        end
    end

    // limit bytes and clock divider, each written on its own
    always_ff @(posedge mclk) begin
        if (rst) begin
            upperLow_reg  <= `ACC_RST_LIMIT_BYTE; // R16
            upperHigh_reg <= `ACC_RST_LIMIT_BYTE;
            lowerLow_reg  <= `ACC_RST_LOWER_BYTE;
            lowerHigh_reg <= `ACC_RST_LOWER_BYTE;
            clkDiv_reg    <= `ACC_RST_CLKDIV;
        end else if (regWrite) begin
            unique case (regAddr)
                `ACC_OFF_UPPER_LOW:  upperLow_reg  <= regWdata; // R13
                `ACC_OFF_UPPER_HIGH: upperHigh_reg <= regWdata; // R13
                `ACC_OFF_LOWER_LOW:  lowerLow_reg  <= regWdata; // R13
                `ACC_OFF_LOWER_HIGH: lowerHigh_reg <= regWdata; // R13
                `ACC_OFF_CLKDIV:     clkDiv_reg    <= regWdata;
                default: begin
                end
            endcase
        end
    end

    // registered read data; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            unique case (regAddr)
                `ACC_OFF_CONTROL: regRdata <= {converterOn_reg,
                                               trackSelect_reg,
                                               convDoneFlag_reg,
                                               state_reg != ACC_IDLE,
                                               startSourceSel_reg,
                                               windowHitFlag_reg,
                                               leftAlignSel_reg}; // R18
                `ACC_OFF_RES_LOW:    regRdata <= resAligned[7:0];
                `ACC_OFF_RES_HIGH:   regRdata <= resAligned[15:8];
                `ACC_OFF_UPPER_LOW:  regRdata <= upperLow_reg;
                `ACC_OFF_UPPER_HIGH: regRdata <= upperHigh_reg;
                `ACC_OFF_LOWER_LOW:  regRdata <= lowerLow_reg;
                `ACC_OFF_LOWER_HIGH: regRdata <= lowerHigh_reg;
                `ACC_OFF_CLKDIV:     regRdata <= clkDiv_reg;
                default:             regRdata <= 8'h00;
            endcase
        end
    end

    assign converterPowered = converterOn_reg; // R1
    assign convDoneIrq      = convDoneFlag_reg;
    assign windowHitIrq     = windowHitFlag_reg; // R14

endmodule : acc_conv_ctrl

`default_nettype wire

/* design/acc_params.svh */
// register offsets, field positions, reset values and timing counts
// for the converter control block; included by the design, checker and bench
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

`define ACC_OFF_RES_LOW     8'hBE
`define ACC_OFF_RES_HIGH    8'hBF
`define ACC_OFF_UPPER_LOW   8'hC4
`define ACC_OFF_UPPER_HIGH  8'hC5
`define ACC_OFF_LOWER_LOW   8'hC6
`define ACC_OFF_LOWER_HIGH  8'hC7
`define ACC_OFF_CONTROL     8'hE8
`define ACC_OFF_CLKDIV      8'hBC

`define ACC_BIT_ON          7
`define ACC_BIT_TRACK       6
`define ACC_BIT_DONE        5
`define ACC_BIT_ACTIVE      4
`define ACC_BIT_SRC_HI      3
`define ACC_BIT_SRC_LO      2
`define ACC_BIT_HIT         1
`define ACC_BIT_LEFT        0

`define ACC_RST_CONTROL     8'h00
`define ACC_RST_LIMIT_BYTE  8'hFF
`define ACC_RST_LOWER_BYTE  8'h00
`define ACC_RST_CLKDIV      8'h27

`define ACC_TRACK_CLKS      3
`define ACC_CONV_CLKS       16

`endif

/* design/acc_pkg.sv */
// types shared by the converter control block
// assumes acc_params.svh is on the include path
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_SRC_SOFT   = 2'b00,
        ACC_SRC_TIMERB = 2'b01,
        ACC_SRC_STROBE = 2'b10,
        ACC_SRC_TIMERA = 2'b11
    } acc_src_t;

    typedef enum logic [1:0] {
        ACC_IDLE  = 2'b00,
        ACC_TRACK = 2'b01,
        ACC_CONV  = 2'b10
    } acc_state_t;
endpackage : acc_pkg

/* verif/acc_analog_model.sv */
// behavioural analog sampling core
// assumes sampleHold high means track, low means hold
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model (
    input  wire logic        mclk,
    input  wire logic        converterPowered,
    input  wire logic        sampleHold,
    input  wire logic [11:0] setCode,
    output logic      [11:0] analogCode
);
    logic [11:0] heldReg;
    // sample follows the input only while tracking
    always_ff @(posedge mclk) begin
        if (sampleHold) heldReg <= setCode;
    end
    // unpowered core shows junk, never a stale good code
    assign analogCode = converterPowered ? heldReg : ~heldReg;
endmodule : acc_analog_model
`default_nettype wire

/* verif/acc_conv_ctrl_chk.sv */
// port checker for the converter control block
// bound to acc_conv_ctrl; sees its ports only
`include "acc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module acc_conv_ctrl_chk #(
    parameter int RES_W = 12
) (
    input wire logic             mclk,
    input wire logic             rst,
    input wire logic [7:0]       regAddr,
    input wire logic [7:0]       regWdata,
    input wire logic             regWrite,
    input wire logic             regRead,
    input wire logic [7:0]       regRdata,
    input wire logic             timerAOvf,
    input wire logic             timerBOvf,
    input wire logic             extConvertStrobe,
    input wire logic [RES_W-1:0] analogCode,
    input wire logic             converterPowered,
    input wire logic             sampleHold,
    input wire logic             convDoneIrq,
    input wire logic             windowHitIrq
);
    logic ctlWr;
    // any write to the control register
    assign ctlWr = regWrite && regAddr == `ACC_OFF_CONTROL;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0) rst |=>
        regRdata == 8'h00 && !converterPowered && !convDoneIrq
        && !windowHitIrq) else $error("outputs not quiet in reset");
    a_off_no_track: assert property (!converterPowered |-> !sampleHold)
        else $error("tracking while unpowered");
    a_power_follows: assert property (ctlWr |=>
        converterPowered == $past(regWdata[7])) else $error("power bit");
    a_done_holds: assert property (convDoneIrq &&
        !(ctlWr && !regWdata[5]) |=> convDoneIrq) else $error("done lost");
    a_hit_holds: assert property (windowHitIrq &&
        !(ctlWr && !regWdata[1]) |=> windowHitIrq) else $error("hit lost");
    a_unmapped_zero: assert property (regRead && regAddr == 8'h00 |=>
        regRdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_stands: assert property (!regRead |=> $stable(regRdata))
        else $error("read data moved without a read");
    // idle tracking stops for the first 8 cycles after a software start
    a_conv_holds: assert property (sampleHold && ctlWr &&
        regWdata[7:6] == 2'b10 && regWdata[4] && regWdata[3:2] == 2'b00
        |=> !sampleHold [*8]) else $error("tracking during conversion");
    a_done_powered: assert property ($rose(convDoneIrq) &&
        !$past(ctlWr) |-> $past(converterPowered)) else $error("done off");
    c_start: cover property (ctlWr && regWdata[4]);
    c_done: cover property ($rose(convDoneIrq));
    c_hit: cover property ($rose(windowHitIrq));
endmodule : acc_conv_ctrl_chk
bind acc_conv_ctrl acc_conv_ctrl_chk #(.RES_W(RES_W)) u_acc_conv_ctrl_chk (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .timerAOvf(timerAOvf), .timerBOvf(timerBOvf),
    .extConvertStrobe(extConvertStrobe), .analogCode(analogCode),
    .converterPowered(converterPowered), .sampleHold(sampleHold),
    .convDoneIrq(convDoneIrq), .windowHitIrq(windowHitIrq));
`default_nettype wire

/* verif/tb_top.sv */
// register-level bench for the converter control block
// assumes clkDiv written 0 so a converter tick comes every cycle
`include "acc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk, rst, regWrite, regRead, timerAOvf, timerBOvf;
    logic extConvertStrobe, converterPowered, sampleHold;
    logic convDoneIrq, windowHitIrq;
    logic [7:0] regAddr, regWdata, regRdata;
    logic [11:0] analogCode, setCode;
    int nErrors = 0, testsRun = 0, cyc = 0, c, h;
    acc_conv_ctrl u_acc_conv_ctrl (.mclk(mclk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .timerAOvf(timerAOvf),
        .timerBOvf(timerBOvf), .extConvertStrobe(extConvertStrobe),
        .analogCode(analogCode), .converterPowered(converterPowered),
        .sampleHold(sampleHold), .convDoneIrq(convDoneIrq),
        .windowHitIrq(windowHitIrq));
    acc_analog_model u_acc_analog_model (.mclk(mclk),
        .converterPowered(converterPowered), .sampleHold(sampleHold),
        .setCode(setCode), .analogCode(analogCode));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        testsRun++;
        if (s !== e) begin
            nErrors++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // each access opens on its own edge so no strobe is set twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask : rd
    task automatic setLim(input logic [15:0] g, input logic [15:0] l);
        wr(`ACC_OFF_UPPER_LOW, g[7:0]);
        wr(`ACC_OFF_UPPER_HIGH, g[15:8]);
        wr(`ACC_OFF_LOWER_LOW, l[7:0]);
        wr(`ACC_OFF_LOWER_HIGH, l[15:8]);
    endtask : setLim
    // bounded wait; also counts tracking cycles on the way
    // first look is just after the start edge so no track cycle is missed
    task automatic waitDone;
        c = 0;
        h = 0;
        #1;
        while (convDoneIrq !== 1'b1 && c < 60) begin
            c++;
            h += int'(sampleHold === 1'b1);
            @(posedge mclk);
            #1;
        end
    endtask : waitDone
    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tallyAndFinish
    // hang guard well beyond the expected run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            nErrors++;
            tallyAndFinish();
        end
    end
    initial begin
        rst = 1'b1;
        {regWrite, regRead, timerAOvf, timerBOvf} = 4'h0;
        {extConvertStrobe, regAddr, regWdata, setCode} = '0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rd(`ACC_OFF_UPPER_LOW, 8'hFF);
        rd(`ACC_OFF_CONTROL, 8'h00);
        rd(8'h00, 8'h00);
        rd(`ACC_OFF_CLKDIV, `ACC_RST_CLKDIV);
        wr(`ACC_OFF_CLKDIV, 8'h00);
        $display("test reset values done");
        setLim(16'h0100, 16'h0200);
        rd(`ACC_OFF_UPPER_HIGH, 8'h01);
        rd(`ACC_OFF_LOWER_HIGH, 8'h02);
        setCode <= 12'h180;
        wr(`ACC_OFF_CONTROL, 8'h80);
        wr(`ACC_OFF_CONTROL, 8'h90);
        waitDone();
        chk(16'(c >= 16 && c <= 20), 16'h0001);
        chk(windowHitIrq, 1'b1);
        rd(`ACC_OFF_RES_LOW, 8'h80);
        rd(`ACC_OFF_RES_HIGH, 8'h01);
        rd(`ACC_OFF_CONTROL, 8'hA2);
        wr(`ACC_OFF_CONTROL, 8'h80);
        rd(`ACC_OFF_CONTROL, 8'h80);
        $display("test soft start inside window done");
        setCode <= 12'hABC;
        wr(`ACC_OFF_CONTROL, 8'h91);
        rd(`ACC_OFF_CONTROL, 8'h91);
        waitDone();
        rd(`ACC_OFF_RES_HIGH, 8'hAB);
        rd(`ACC_OFF_RES_LOW, 8'hC0);
        rd(`ACC_OFF_CONTROL, 8'hA1);
        wr(`ACC_OFF_CONTROL, 8'h80);
        repeat (30) @(posedge mclk);
        chk(convDoneIrq, 1'b0);
        wr(`ACC_OFF_CONTROL, 8'h10);
        repeat (30) @(posedge mclk);
        chk({converterPowered, convDoneIrq}, 2'b00);
        $display("test left align and refusals done");
        setLim(16'h0200, 16'h0100);
        setCode <= 12'h050;
        for (int s = 0; s < 4; s++) begin
            wr(`ACC_OFF_CONTROL, 8'hC0 | 8'(s << 2));
            // every start lands on the edge at which waitDone begins
            if (s == 0) begin
                wr(`ACC_OFF_CONTROL, 8'hD0);
            end else begin
                @(posedge mclk);
                timerBOvf <= (s == 1);
                extConvertStrobe <= (s == 2);
                timerAOvf <= (s == 3);
                @(posedge mclk);
                {timerAOvf, timerBOvf} <= 2'b00;
            end
            waitDone();
            chk(16'(h), (s == 2) ? 16'h0000 : 16'h0003);
            rd(`ACC_OFF_CONTROL, 8'hE2 | 8'(s << 2));
            wr(`ACC_OFF_CONTROL, 8'hC0 | 8'(s << 2));
            extConvertStrobe <= 1'b0;
        end
        $display("test start sources outside window done");
        tallyAndFinish();
    end
endmodule : tb_top
`default_nettype wire
